//--- hw/dsau_pkg.sv
// Package for the data space access unit: address map, sizes, widths and
// the packed request and answer carriers.
// Assumes a single core clock and a synchronous active-high reset.
package dsau_pkg;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned NEAR_ADDR_W = 13;
  localparam int unsigned BYTE_W = 8;
  localparam logic [ADDR_W-1:0] SFR_FIRST = 16'h0000;
  localparam logic [ADDR_W-1:0] SFR_LAST = 16'h0FFF;
  localparam logic [ADDR_W-1:0] NEAR_LAST = 16'h1FFF;
  // Fixed X/Y boundary; Y RAM begins here and is not programmable.
  localparam logic [ADDR_W-1:0] Y_FIRST = 16'h4000;
  // Top of implemented RAM; addresses above read as zero.
  localparam logic [ADDR_W-1:0] RAM_LAST = 16'hCFFF;
  localparam logic [ADDR_W-1:0] STEP_BYTE = 16'h0001;
  localparam logic [ADDR_W-1:0] STEP_WORD = 16'h0002;
  localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;
  localparam logic [BYTE_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [BYTE_W-1:0] ONES_BYTE = 8'hFF;
  localparam int unsigned WREG_N = 16;
  localparam int unsigned WIDX_W = 4;
  localparam logic [1:0] LANES_NONE = 2'h0;
  localparam logic [1:0] LANES_BOTH = 2'h3;
  localparam logic [1:0] LANE_LOW = 2'h1;
  localparam logic [1:0] LANE_HIGH = 2'h2;

  // Address source for the X generator.
  typedef enum logic [3:0] {
    DSAU_AM_NEAR = 4'h1,
    DSAU_AM_DIRECT = 4'h2,
    DSAU_AM_IND = 4'h4,
    DSAU_AM_IND_POSTINC = 4'h8
  } dsau_amode_t;

  // Working-register update on a load.
  typedef enum logic [3:0] {
    DSAU_WB_NONE = 4'h1,
    DSAU_WB_LOAD = 4'h2,
    DSAU_WB_SIGN_EXTEND = 4'h4,
    DSAU_WB_ZERO_EXTEND = 4'h8
  } dsau_wb_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic byte_op;
    dsau_amode_t amode;
    logic [WIDX_W-1:0] ptr_reg;
    logic [ADDR_W-1:0] direct_addr;
    logic [NEAR_ADDR_W-1:0] near_addr;
    logic [DATA_W-1:0] wdata;
    dsau_wb_t wb;
    logic [WIDX_W-1:0] dst_reg;
  } dsau_xreq_t;

  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
  } dsau_yreq_t;

  typedef struct packed {
    logic we;
    logic [1:0] lanes;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } dsau_mwr_t;
endpackage

//--- hw/dsau_addr_gen.sv
// Address generator: effective byte address, pointer step and checks.
// Assumes the pointer value is supplied from the working register file.
`timescale 1ns/10ps
module dsau_addr_gen (
  // Request
  input wire logic i_byte_op,
  input wire dsau_pkg::dsau_amode_t i_amode,
  input wire logic [dsau_pkg::ADDR_W-1:0] i_ptr,
  input wire logic [dsau_pkg::ADDR_W-1:0] i_direct_addr,
  input wire logic [dsau_pkg::NEAR_ADDR_W-1:0] i_near_addr,
  // Result
  output logic [dsau_pkg::ADDR_W-1:0] o_effective_byte_address,
  output logic [dsau_pkg::ADDR_W-1:0] o_next_ptr,
  output logic o_ptr_update,
  output logic o_misaligned,
  output logic o_in_ram,
  output logic o_in_sfr
);
  import dsau_pkg::*;
  logic [ADDR_W-1:0] ea;

  always_comb begin
    ea = i_ptr;
    o_ptr_update = 1'b0;
    case (i_amode)
      DSAU_AM_NEAR: ea = {{(ADDR_W-NEAR_ADDR_W){1'b0}}, i_near_addr};
      DSAU_AM_DIRECT: ea = i_direct_addr;
      DSAU_AM_IND: ea = i_ptr;
      DSAU_AM_IND_POSTINC: begin
        ea = i_ptr;
        o_ptr_update = 1'b1;
      end
      default: ea = i_ptr;
    endcase
  end

  assign o_next_ptr = i_ptr + (i_byte_op ? STEP_BYTE : STEP_WORD);
  assign o_effective_byte_address = ea;
  assign o_misaligned = !i_byte_op && ea[0];
  assign o_in_sfr = (ea >= SFR_FIRST) && (ea <= SFR_LAST);
  assign o_in_ram = (ea > SFR_LAST) && (ea <= RAM_LAST);
endmodule

//--- hw/dsau_lane_sel.sv
// Read lane selector: picks a byte from a fetched word onto the low byte.
// Assumes the fetched word was already forced to zero where unmapped.
`timescale 1ns/10ps
module dsau_lane_sel (
  // Fetched word
  input wire logic [dsau_pkg::DATA_W-1:0] i_word,
  input wire logic i_byte_op,
  input wire logic i_odd,
  // Delivered data
  output logic [dsau_pkg::DATA_W-1:0] o_data
);
  import dsau_pkg::*;
  assign o_data = !i_byte_op ? i_word :
    {ZERO_BYTE, i_odd ? i_word[DATA_W-1:BYTE_W] : i_word[BYTE_W-1:0]};
endmodule

//--- hw/dsau_top.sv
// Data space access unit: X/Y address generation, byte lanes, alignment
// trap, region decode and working-register load write-back.
// Assumes memory and registers answer a word read combinationally.
`timescale 1ns/10ps
module dsau_top (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // X request from the execution unit
  input wire dsau_pkg::dsau_xreq_t i_xreq,
  // Y request, multiply-accumulate class only
  input wire dsau_pkg::dsau_yreq_t i_yreq,
  input wire logic i_multiply_accumulate_class,
  // Words fetched from memory and registers at the driven addresses
  input wire logic [dsau_pkg::DATA_W-1:0] i_x_mem_word,
  input wire logic [dsau_pkg::DATA_W-1:0] i_y_mem_word,
  input wire logic i_sfr_implemented,
  // Memory side
  output logic [dsau_pkg::ADDR_W-1:0] o_x_rd_addr,
  output logic [dsau_pkg::ADDR_W-1:0] o_y_rd_addr,
  output dsau_pkg::dsau_mwr_t o_x_wr,
  // Results to the execution unit
  output logic [dsau_pkg::DATA_W-1:0] o_x_rdata,
  output logic [dsau_pkg::DATA_W-1:0] o_y_rdata,
  output logic o_x_rvalid,
  output logic o_y_rvalid,
  output logic [dsau_pkg::ADDR_W-1:0] o_effective_byte_address,
  output logic o_address_error,
  // Working register file view
  output logic [dsau_pkg::WREG_N*dsau_pkg::DATA_W-1:0] o_wregs
);
  import dsau_pkg::*;

  logic [DATA_W-1:0] wreg [WREG_N];
  logic [ADDR_W-1:0] ea;
  logic [ADDR_W-1:0] next_ptr;
  logic ptr_update;
  logic misaligned;
  logic in_ram;
  logic in_sfr;
  logic [DATA_W-1:0] x_word;
  logic [DATA_W-1:0] y_word;
  logic [DATA_W-1:0] x_sel;
  logic [DATA_W-1:0] y_sel;
  logic y_in_ram;
  logic y_ok;
  logic do_write;
  logic [1:0] next_lanes;
  logic [DATA_W-1:0] next_wdata;

  dsau_addr_gen u_xgen (
    .i_byte_op(i_xreq.byte_op),
    .i_amode(i_xreq.amode),
    .i_ptr(wreg[i_xreq.ptr_reg]),
    .i_direct_addr(i_xreq.direct_addr),
    .i_near_addr(i_xreq.near_addr),
    .o_effective_byte_address(ea),
    .o_next_ptr(next_ptr),
    .o_ptr_update(ptr_update),
    .o_misaligned(misaligned),
    .o_in_ram(in_ram),
    .o_in_sfr(in_sfr)
  );

  assign x_word = (in_ram || (in_sfr && i_sfr_implemented)) ?
    i_x_mem_word : ZERO_WORD;

  dsau_lane_sel u_xsel (
    .i_word(x_word),
    .i_byte_op(i_xreq.byte_op),
    .i_odd(ea[0]),
    .o_data(x_sel)
  );

  assign y_ok = i_yreq.valid && i_multiply_accumulate_class &&
    !i_yreq.addr[0];
  // Fixed boundary, Y is RAM only.
  assign y_in_ram = (i_yreq.addr >= Y_FIRST) && (i_yreq.addr <= RAM_LAST);
  assign y_word = y_in_ram ? i_y_mem_word : ZERO_WORD;

  dsau_lane_sel u_ysel (
    .i_word(y_word),
    .i_byte_op(1'b0),
    .i_odd(1'b0),
    .o_data(y_sel)
  );

  assign do_write = i_xreq.valid && i_xreq.write && !misaligned;

  always_comb begin
    next_lanes = LANES_NONE;
    next_wdata = i_xreq.wdata;
    if (do_write) begin
      if (!i_xreq.byte_op) begin
        next_lanes = LANES_BOTH;
      end else if (ea[0]) begin
        next_lanes = LANE_HIGH;
        next_wdata = {i_xreq.wdata[BYTE_W-1:0], i_xreq.wdata[BYTE_W-1:0]};
      end else begin
        next_lanes = LANE_LOW;
        next_wdata = {i_xreq.wdata[BYTE_W-1:0], i_xreq.wdata[BYTE_W-1:0]};
      end
    end
  end

  // The fetched words come back in the request cycle; these registered
  // word addresses only report what was fetched, one cycle late.
  // Two concurrent read addresses.
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_x_rd_addr <= ZERO_WORD;
      o_y_rd_addr <= ZERO_WORD;
    end else begin
      o_x_rd_addr <= {ea[ADDR_W-1:1], 1'b0};
      o_y_rd_addr <= {i_yreq.addr[ADDR_W-1:1], 1'b0};
    end
  end

  // Address taken unmodified.
  // Modulo and bit-reversed stepping live upstream, so writes take it as is.
  // Writes see one combined space.
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_x_wr <= '0;
    end else begin
      o_x_wr.we <= do_write;
      o_x_wr.lanes <= next_lanes;
      o_x_wr.addr <= {ea[ADDR_W-1:1], 1'b0};
      o_x_wr.data <= next_wdata;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_x_rdata <= ZERO_WORD;
      o_x_rvalid <= 1'b0;
      o_effective_byte_address <= ZERO_WORD;
    end else begin
      o_x_rdata <= x_sel;
      o_x_rvalid <= i_xreq.valid && !i_xreq.write;
      o_effective_byte_address <= ea;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_y_rdata <= ZERO_WORD;
      o_y_rvalid <= 1'b0;
    end else begin
      o_y_rdata <= y_ok ? y_sel : ZERO_WORD;
      o_y_rvalid <= y_ok;
    end
  end

  // Trap after the access.
  // The pulse lands with the completed result, so the exception logic
  // sees the state left by the faulting instruction, minus any write.
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_address_error <= 1'b0;
    end else begin
      o_address_error <= i_xreq.valid && misaligned;
    end
  end

  // Working registers; load write-back, pointer update and extension.
  // A word load into the pointer register itself wins over the post-increment; a byte load replaces only its low byte.
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      for (int i = 0; i < WREG_N; i++) begin
        wreg[i] <= ZERO_WORD;
      end
    end else if (i_xreq.valid) begin
      if (ptr_update) begin
        wreg[i_xreq.ptr_reg] <= next_ptr;
      end
      case (i_xreq.wb)
        DSAU_WB_LOAD: begin
          if (!i_xreq.write) begin
            if (i_xreq.byte_op) begin
              wreg[i_xreq.dst_reg][BYTE_W-1:0] <= x_sel[BYTE_W-1:0];
            end else begin
              wreg[i_xreq.dst_reg] <= x_sel;
            end
          end
        end
        DSAU_WB_SIGN_EXTEND: begin
          wreg[i_xreq.dst_reg][DATA_W-1:BYTE_W] <=
            wreg[i_xreq.dst_reg][BYTE_W-1] ? ONES_BYTE : ZERO_BYTE;
        end
        DSAU_WB_ZERO_EXTEND: begin
          wreg[i_xreq.dst_reg][DATA_W-1:BYTE_W] <= ZERO_BYTE;
        end
        default: begin
        end
      endcase
    end
  end

  // Register view flattened for the core; it is a copy so the output is
  // a flip-flop, one cycle behind the working registers.
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_wregs <= '0;
    end else begin
      for (int i = 0; i < WREG_N; i++) begin
        o_wregs[i*DATA_W +: DATA_W] <= wreg[i];
      end
    end
  end
endmodule

//--- verif/dsau_mem_model.sv
// Behavioural data memory standing beside the access unit.
// Assumes the bench presents both effective addresses in the request cycle.
`timescale 1ns/10ps
module dsau_mem_model (
  // Addresses
  input wire logic [dsau_pkg::ADDR_W-1:0] i_x_addr,
  input wire logic [dsau_pkg::ADDR_W-1:0] i_y_addr,
  // Answers
  output logic [dsau_pkg::DATA_W-1:0] o_x_word,
  output logic [dsau_pkg::DATA_W-1:0] o_y_word,
  output logic o_sfr_implemented
);
  // Content depends on the word address only, so both lanes are distinct.
  assign o_x_word = {i_x_addr[7:1], 1'b0, i_x_addr[15:8]} ^ 16'hA5C3;
  assign o_y_word = {i_y_addr[7:1], 1'b0, i_y_addr[15:8]} ^ 16'h3C5A;
  // Every other 32-byte block of the register region is left empty.
  assign o_sfr_implemented = ~i_x_addr[5];
endmodule

//--- verif/dsau_checker_assertions.sv
// Port checker for the data space access unit.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/10ps
module dsau_checker (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // Requests
  input wire dsau_pkg::dsau_xreq_t i_xreq,
  input wire dsau_pkg::dsau_yreq_t i_yreq,
  input wire logic i_multiply_accumulate_class,
  input wire logic i_sfr_implemented,
  // Answers
  input wire dsau_pkg::dsau_mwr_t o_x_wr,
  input wire logic [dsau_pkg::DATA_W-1:0] o_x_rdata,
  input wire logic o_x_rvalid,
  input wire logic o_y_rvalid,
  input wire logic [dsau_pkg::ADDR_W-1:0] o_effective_byte_address,
  input wire logic o_address_error
);
  import dsau_pkg::*;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  sequence s_word_req;
    i_xreq.valid && !i_xreq.byte_op;
  endsequence
  sequence s_read_req;
    i_xreq.valid && !i_xreq.write;
  endsequence
  sequence s_y_ok;
    i_yreq.valid && i_multiply_accumulate_class && !i_yreq.addr[0];
  endsequence
  a_err_raised: assert property (
    s_word_req ##1 o_effective_byte_address[0] |-> o_address_error)
    else $error("no address error on odd word access");
  a_err_cause: assert property (
    o_address_error |-> $past(i_xreq.valid && !i_xreq.byte_op)
      && o_effective_byte_address[0])
    else $error("address error without odd word access");
  a_write_dropped: assert property (
    o_address_error && $past(i_xreq.write) |-> !o_x_wr.we
      && o_x_wr.lanes == LANES_NONE)
    else $error("faulting write reached memory");
  a_byte_lane: assert property (
    $past(i_xreq.valid && i_xreq.write && i_xreq.byte_op) && o_x_wr.we |->
      o_x_wr.lanes == (o_effective_byte_address[0] ? LANE_HIGH : LANE_LOW))
    else $error("byte write strobes wrong lane");
  a_write_even: assert property (
    o_x_wr.we |-> o_x_wr.addr == {o_effective_byte_address[15:1], 1'b0})
    else $error("write address not the containing word");
  a_read_done: assert property (
    s_read_req |=> o_x_rvalid)
    else $error("read not completed");
  a_byte_low: assert property (
    s_read_req ##0 i_xreq.byte_op |=> o_x_rdata[15:8] == ZERO_BYTE)
    else $error("byte read high byte not clear");
  a_y_class: assert property (
    o_y_rvalid |-> $past(i_yreq.valid && i_multiply_accumulate_class
      && !i_yreq.addr[0]))
    else $error("second read path used outside its class");
  a_dual_fetch: assert property (
    s_read_req ##0 s_y_ok |=> o_x_rvalid && o_y_rvalid)
    else $error("two concurrent reads not served");
  a_zero_above: assert property (
    o_x_rvalid && o_effective_byte_address > RAM_LAST |->
      o_x_rdata == ZERO_WORD)
    else $error("unimplemented address read non-zero");
  a_sfr_gap: assert property (
    s_read_req ##0 !i_sfr_implemented ##1
      o_effective_byte_address <= SFR_LAST |-> o_x_rdata == ZERO_WORD)
    else $error("empty register slot read non-zero");
  a_near_field: assert property (
    i_xreq.valid && i_xreq.amode == DSAU_AM_NEAR |=>
      o_effective_byte_address == {3'h0, $past(i_xreq.near_addr)})
    else $error("near address field not used");
endmodule
bind dsau_top dsau_checker dsau_checker_inst (
  .i_ref_clk(i_ref_clk),
  .i_reset(i_reset),
  .i_xreq(i_xreq),
  .i_yreq(i_yreq),
  .i_multiply_accumulate_class(i_multiply_accumulate_class),
  .i_sfr_implemented(i_sfr_implemented),
  .o_x_wr(o_x_wr),
  .o_x_rdata(o_x_rdata),
  .o_x_rvalid(o_x_rvalid),
  .o_y_rvalid(o_y_rvalid),
  .o_effective_byte_address(o_effective_byte_address),
  .o_address_error(o_address_error)
);

//--- verif/data_space_access_unit_tb.sv
// Random self-checking bench for the data space access unit.
// Assumes answers arrive one cycle after each request, as handed over.
`timescale 1ns/10ps
module data_space_access_unit_tb;
  import dsau_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_reset = 1'b1;
  dsau_xreq_t xreq, p;
  dsau_yreq_t yreq;
  dsau_mwr_t x_wr;
  logic mac, special_register_region, p_sfr, p_yok, x_rv, y_rv, err;
  logic [15:0] x_ea, x_word, y_word, x_rd, y_rd, ea_out, x_ra, y_ra;
  logic [15:0] p_ea, p_word, p_yword, p_yaddr;
  logic [WREG_N*DATA_W-1:0] wregs;
  logic [15:0] mw [WREG_N];
  dsau_amode_t amodes [4] = '{DSAU_AM_NEAR, DSAU_AM_DIRECT, DSAU_AM_IND,
    DSAU_AM_IND_POSTINC};
  dsau_wb_t wbs [4] = '{DSAU_WB_NONE, DSAU_WB_LOAD, DSAU_WB_SIGN_EXTEND,
    DSAU_WB_ZERO_EXTEND};
  int bad_count = 0;
  int checks_done = 0;
  int seed = 32;
  initial forever #20 i_ref_clk = ~i_ref_clk;
  dsau_top dsau_top_inst (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
    .i_xreq(xreq), .i_yreq(yreq), .i_multiply_accumulate_class(mac),
    .i_x_mem_word(x_word), .i_y_mem_word(y_word), .i_sfr_implemented(special_register_region),
    .o_x_rd_addr(x_ra), .o_y_rd_addr(y_ra), .o_x_wr(x_wr), .o_x_rdata(x_rd),
    .o_y_rdata(y_rd), .o_x_rvalid(x_rv), .o_y_rvalid(y_rv),
    .o_effective_byte_address(ea_out), .o_address_error(err),
    .o_wregs(wregs));
  dsau_mem_model dsau_mem_model_inst (.i_x_addr(x_ea), .i_y_addr(yreq.addr),
    .o_x_word(x_word), .o_y_word(y_word), .o_sfr_implemented(special_register_region));
  task automatic chk(input string what, input logic [15:0] e,
      input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic check_prev();
    logic [15:0] rd, b;
    logic mis;
    mis = !p.byte_op && p_ea[0];
    rd = p_word;
    if (p_ea > RAM_LAST || (p_ea <= SFR_LAST && !p_sfr)) rd = ZERO_WORD;
    b = {ZERO_BYTE, p_ea[0] ? rd[15:8] : rd[7:0]};
    for (int i = 0; i < WREG_N; i++)
      chk("wreg", mw[i], wregs[i*16 +: 16]);
    chk("error", 16'(p.valid && mis), 16'(err));
    if (p.valid) chk("ea", p_ea, ea_out);
    if (p.valid) chk("x_rd_addr", {p_ea[15:1], 1'b0}, x_ra);
    if (p.valid) chk("y_rd_addr", {p_yaddr[15:1], 1'b0}, y_ra);
    chk("rvalid", 16'(p.valid && !p.write), 16'(x_rv));
    if (p.valid && !p.write && !mis)
      chk("rdata", p.byte_op ? b : rd, x_rd);
    if (p.valid && p.write && p_ea <= RAM_LAST)
      chk("we", 16'(!mis), 16'(x_wr.we));
    if (p.valid && p.write && x_wr.we) chk("wr_addr", {p_ea[15:1], 1'b0},
      x_wr.addr);
    if (p.valid && p.write && x_wr.we && p.byte_op) chk("lane",
      16'(p_ea[0] ? LANE_HIGH : LANE_LOW), 16'(x_wr.lanes));
    if (p.valid && p.write && x_wr.we) chk("wdata", p.byte_op ?
      {2{p.wdata[7:0]}} : p.wdata, x_wr.data);
    chk("y_rvalid", 16'(p_yok), 16'(y_rv));
    chk("y_rdata", (!p_yok || p_yaddr > RAM_LAST) ? ZERO_WORD : p_yword,
      y_rd);
    if (p.valid && p.amode == DSAU_AM_IND_POSTINC)
      mw[p.ptr_reg] += p.byte_op ? STEP_BYTE : STEP_WORD;
    if (p.valid && !p.write) begin
      case (p.wb)
        DSAU_WB_LOAD: if (p.byte_op) mw[p.dst_reg][7:0] = b[7:0];
          else mw[p.dst_reg] = rd;
        DSAU_WB_SIGN_EXTEND: mw[p.dst_reg] =
          {{8{mw[p.dst_reg][7]}}, mw[p.dst_reg][7:0]};
        DSAU_WB_ZERO_EXTEND: mw[p.dst_reg][15:8] = ZERO_BYTE;
        default: ;
      endcase
    end
  endtask
  task automatic drive(input logic on);
    dsau_xreq_t r;
    logic [31:0] v;
    r = {$random(seed), $random(seed)};
    v = $random(seed);
    r.valid = on;
    r.amode = amodes[v[1:0]];
    r.wb = r.write ? DSAU_WB_NONE : wbs[v[3:2]];
    case (r.amode)
      DSAU_AM_NEAR: x_ea = {3'h0, r.near_addr};
      DSAU_AM_DIRECT: x_ea = r.direct_addr;
      default: x_ea = mw[r.ptr_reg];
    endcase
    // A faulting load has no defined data, so it is never asked for.
    if (!r.byte_op && x_ea[0]) r.wb = DSAU_WB_NONE;
    if (r.wb inside {DSAU_WB_SIGN_EXTEND, DSAU_WB_ZERO_EXTEND})
      r.dst_reg = r.ptr_reg ^ 4'h8;
    xreq = r;
    yreq = '{v[4], Y_FIRST | v[31:16]};
    mac = v[5];
    #1;
    p = r;
    p_ea = x_ea;
    p_word = x_word;
    p_sfr = special_register_region;
    p_yok = v[4] && v[5] && !v[16];
    p_yword = y_word;
    p_yaddr = yreq.addr;
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    xreq = '0;
    p = '0;
    yreq = '0;
    mac = 1'b0;
    x_ea = '0;
    p_yok = 1'b0;
    foreach (mw[i]) mw[i] = ZERO_WORD;
    repeat (5) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    i_reset = 1'b0;
    repeat (600) begin
      @(negedge i_ref_clk);
      check_prev();
      drive(($random(seed) & 7) != 0);
    end
    @(negedge i_ref_clk);
    check_prev();
    results();
  end
  // The run needs about 610 cycles; allow twice that before giving up.
  initial begin
    #(1220 * 40);
    bad_count++;
    results();
  end
endmodule
